// ---- hw/slwc_ctrl.sv ----
// Clock select, power mode, settling hold and low-voltage detect control.
//
// Functional notes
// - Interrupt enable gates low-voltage interrupt request.
// - Detector enable; disabled status reads one.
// - Level field selects threshold; status above.
// - Threshold crossing either way raises event.
// - Wake register bits three..one read zero.
// - Bit zero enables external pin wake.
// - Control bits seven, three, two read zero.
// - Timer clock select, main by default.
// - CPU clock select, main by default.
// - Sub clock selected stops main oscillator.
// - Idle bit chooses sleep or idle.
// - Count 510 or 8 clocks after stable.
// - Two-bit RC frequency select encoding.
// - RC select loaded from code option.
// - RC change with no same-cycle sleep or CPU select change holds for new settling time.
// - Status clear when low; sticky interrupt flag.
`timescale 1ns/1ps
module slwc_ctrl (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic [slwc_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [slwc_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [slwc_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic [1:0] code_option_rc_in,
  input wire logic lowvolt_cmp_above_in,
  input wire logic sleep_instruction_in,
  input wire logic ext_int_n_in,
  input wire logic wake_event_in,
  input wire logic osc_stable_in,
  input wire logic crystal_osc_in,
  input wire logic cpu_clk_tick_in,
  output logic irq_out,
  output logic lowvolt_irq_req_out,
  output logic lowvolt_status_n_out,
  output logic lowvolt_detect_enable_out,
  output logic [1:0] lowvolt_level_out,
  output logic ext_pin_wake_enable_out,
  output logic timer_clock_select_out,
  output logic cpu_clock_select_out,
  output logic main_osc_enable_out,
  output logic [1:0] rc_freq_sel_out,
  output logic sleep_mode_out,
  output logic idle_mode_out,
  output logic cpu_hold_out
);
  import slwc_pkg::*;

  // ------------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------------
  logic lowvolt_irq_enable_r;
  logic lowvolt_detect_enable_r;
  logic lowvolt_level_hi_r;
  logic lowvolt_level_lo_r;
  logic ext_pin_wake_enable_r;
  logic timer_clock_select_r;
  logic cpu_clock_select_r;
  logic idle_select_r;
  logic rc_freq_sel_hi_r;
  logic rc_freq_sel_lo_r;
  logic [IRQ_W-1:0] irq_status_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [DATA_W-1:0] rdata_r;

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  logic wr_lowvolt;
  logic wr_sys;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic [1:0] new_rc_sel;
  logic rc_change;
  logic cpu_sel_change;

  assign wr_lowvolt = reg_wr_in && (reg_addr_in == OFF_LOWVOLT_WAKE);
  assign wr_sys = reg_wr_in && (reg_addr_in == OFF_SYS_CLOCK);
  assign wr_irq_status = reg_wr_in && (reg_addr_in == OFF_IRQ_STATUS);
  assign wr_irq_mask = reg_wr_in && (reg_addr_in == OFF_IRQ_MASK);
  assign new_rc_sel = {reg_wdata_in[SC_RC_HI_BIT], reg_wdata_in[SC_RC_LO_BIT]};
  assign rc_change = wr_sys && (new_rc_sel != {rc_freq_sel_hi_r, rc_freq_sel_lo_r});
  assign cpu_sel_change = wr_sys && (reg_wdata_in[SC_CPU_SEL_BIT] != cpu_clock_select_r);

  // ------------------------------------------------------------------
  // Low-voltage and wake register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      lowvolt_irq_enable_r <= RST_LOWVOLT_WAKE[LW_IRQ_EN_BIT];
      lowvolt_detect_enable_r <= RST_LOWVOLT_WAKE[LW_DET_EN_BIT];
      lowvolt_level_hi_r <= RST_LOWVOLT_WAKE[LW_LEVEL_HI_BIT];
      lowvolt_level_lo_r <= RST_LOWVOLT_WAKE[LW_LEVEL_LO_BIT];
      ext_pin_wake_enable_r <= RST_LOWVOLT_WAKE[LW_EXT_WAKE_BIT];
    end else if (clk_en_in && wr_lowvolt) begin
      lowvolt_irq_enable_r <= reg_wdata_in[LW_IRQ_EN_BIT];
      lowvolt_detect_enable_r <= reg_wdata_in[LW_DET_EN_BIT];
      lowvolt_level_hi_r <= reg_wdata_in[LW_LEVEL_HI_BIT];
      lowvolt_level_lo_r <= reg_wdata_in[LW_LEVEL_LO_BIT];
      ext_pin_wake_enable_r <= reg_wdata_in[LW_EXT_WAKE_BIT];
    end
  end

  // ------------------------------------------------------------------
  // System clock control register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      timer_clock_select_r <= RST_TIMER_SEL;
      cpu_clock_select_r <= RST_CPU_SEL;
      idle_select_r <= RST_IDLE;
      rc_freq_sel_hi_r <= code_option_rc_in[1];
      rc_freq_sel_lo_r <= code_option_rc_in[0];
    end else if (clk_en_in && wr_sys) begin
      timer_clock_select_r <= reg_wdata_in[SC_TIMER_SEL_BIT];
      cpu_clock_select_r <= reg_wdata_in[SC_CPU_SEL_BIT];
      idle_select_r <= reg_wdata_in[SC_IDLE_BIT];
      rc_freq_sel_hi_r <= reg_wdata_in[SC_RC_HI_BIT];
      rc_freq_sel_lo_r <= reg_wdata_in[SC_RC_LO_BIT];
    end
  end

  // ------------------------------------------------------------------
  // Low-voltage detector
  // ------------------------------------------------------------------
  logic cmp_above_sync;
  logic cmp_prev_r;
  logic lowvolt_event;

  slwc_sync2 u_cmp_sync (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .async_in(lowvolt_cmp_above_in),
    .sync_out(cmp_above_sync)
  );

  // The previous sample tracks the comparator only while enabled, so switching
  // the detector on while the supply is low still counts as a crossing.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      cmp_prev_r <= 1'b1;
    end else if (clk_en_in) begin
      cmp_prev_r <= lowvolt_detect_enable_r ? cmp_above_sync : 1'b1;
    end
  end

  assign lowvolt_event = lowvolt_detect_enable_r && (cmp_above_sync != cmp_prev_r);

  assign lowvolt_status_n_out = !lowvolt_detect_enable_r || cmp_above_sync;

  // ------------------------------------------------------------------
  // External pin edge
  // ------------------------------------------------------------------
  logic ext_prev_r;
  logic ext_fall;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ext_prev_r <= 1'b1;
    end else if (clk_en_in) begin
      ext_prev_r <= ext_int_n_in;
    end
  end

  assign ext_fall = ext_prev_r && !ext_int_n_in;

  // ------------------------------------------------------------------
  // Power mode sequencer
  // ------------------------------------------------------------------
  slwc_state_e state_r;
  slwc_state_e state_nxt;
  logic wake_req;
  logic hold_load;
  logic [HOLD_W-1:0] hold_val;
  logic [HOLD_W-1:0] settle_val;
  logic [HOLD_W-1:0] rc_hold_val;
  logic hold_tick;
  logic hold_busy;
  logic hold_done;

  assign wake_req = wake_event_in || (ext_fall && ext_pin_wake_enable_r);

  // long count for crystal entering normal
  assign settle_val = (crystal_osc_in && cpu_clock_select_r) ? SETTLE_LONG_CLK
                                                             : SETTLE_SHORT_CLK;

  always_comb begin
    unique case (new_rc_sel)
      RC_16MHZ: rc_hold_val = RC_HOLD_16M_CYC;
      RC_8MHZ: rc_hold_val = RC_HOLD_8M_CYC;
      RC_4MHZ: rc_hold_val = RC_HOLD_4M_CYC;
      RC_1MHZ: rc_hold_val = RC_HOLD_1M_CYC;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    hold_load = 1'b0;
    hold_val = settle_val;
    unique case (state_r)
      SLWC_RUN, SLWC_RC_HOLD: begin
        if (state_r == SLWC_RUN && sleep_instruction_in) begin
          state_nxt = idle_select_r ? SLWC_IDLE : SLWC_SLEEP;
        end else if (cpu_sel_change) begin
          state_nxt = SLWC_WAIT_OSC;
        end else if (rc_change) begin
          state_nxt = SLWC_RC_HOLD;
          hold_load = 1'b1;
          hold_val = rc_hold_val;
        end else if (state_r == SLWC_RC_HOLD && hold_done) begin
          state_nxt = SLWC_RUN;
        end
      end
      SLWC_SLEEP, SLWC_IDLE: begin
        if (wake_req) begin
          state_nxt = SLWC_WAIT_OSC;
        end
      end
      SLWC_WAIT_OSC: begin
        if (osc_stable_in) begin
          state_nxt = SLWC_SETTLE;
          hold_load = 1'b1;
        end
      end
      SLWC_SETTLE: begin
        if (hold_done) begin
          state_nxt = SLWC_RUN;
        end
      end
      default: begin
        state_nxt = SLWC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_r <= SLWC_RUN;
    end else if (clk_en_in) begin
      state_r <= state_nxt;
    end
  end

  assign hold_tick = (state_r == SLWC_SETTLE) ? cpu_clk_tick_in : 1'b1;

  slwc_hold_timer #(
    .WIDTH(HOLD_W)
  ) u_hold (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .load_in(hold_load && clk_en_in),
    .load_val_in(hold_val),
    .tick_in(hold_tick),
    .busy_out(hold_busy),
    .done_out(hold_done)
  );

  // ------------------------------------------------------------------
  // Interrupt status and mask
  // ------------------------------------------------------------------
  logic [IRQ_W-1:0] irq_set;

  assign irq_set[IRQ_LOWVOLT_BIT] = lowvolt_event;
  assign irq_set[IRQ_WAKE_BIT] = wake_req && (state_r == SLWC_SLEEP || state_r == SLWC_IDLE);
  assign irq_set[IRQ_HOLD_DONE_BIT] = hold_done;

  // A new event in the clearing cycle survives, because set is applied last.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      irq_status_r <= '0;
    end else if (clk_en_in) begin
      irq_status_r <= (irq_status_r & ~(wr_irq_status ? reg_wdata_in[IRQ_W-1:0] : '0))
                      | irq_set;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      irq_mask_r <= RST_IRQ_MASK;
    end else if (clk_en_in && wr_irq_mask) begin
      irq_mask_r <= reg_wdata_in[IRQ_W-1:0];
    end
  end

  assign irq_out = |(irq_status_r & irq_mask_r);

  assign lowvolt_irq_req_out = lowvolt_irq_enable_r && irq_status_r[IRQ_LOWVOLT_BIT];

  // ------------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    unique case (reg_addr_in)
      OFF_LOWVOLT_WAKE: begin
        rd_mux[LW_IRQ_EN_BIT] = lowvolt_irq_enable_r;
        rd_mux[LW_DET_EN_BIT] = lowvolt_detect_enable_r;
        rd_mux[LW_LEVEL_HI_BIT] = lowvolt_level_hi_r;
        rd_mux[LW_LEVEL_LO_BIT] = lowvolt_level_lo_r;
        rd_mux[LW_EXT_WAKE_BIT] = ext_pin_wake_enable_r;
      end
      OFF_SYS_CLOCK: begin
        rd_mux[SC_TIMER_SEL_BIT] = timer_clock_select_r;
        rd_mux[SC_CPU_SEL_BIT] = cpu_clock_select_r;
        rd_mux[SC_IDLE_BIT] = idle_select_r;
        rd_mux[SC_RC_HI_BIT] = rc_freq_sel_hi_r;
        rd_mux[SC_RC_LO_BIT] = rc_freq_sel_lo_r;
      end
      OFF_IRQ_STATUS: begin
        rd_mux[IRQ_W-1:0] = irq_status_r;
      end
      OFF_IRQ_MASK: begin
        rd_mux[IRQ_W-1:0] = irq_mask_r;
      end
      OFF_BLOCK_STATE: begin
        rd_mux = {lowvolt_status_n_out, hold_busy, state_r};
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rdata_r <= '0;
    end else if (clk_en_in) begin
      rdata_r <= reg_rd_in ? rd_mux : '0;
    end
  end

  assign reg_rdata_out = rdata_r;

  // ------------------------------------------------------------------
  // Outputs to the clock tree and core
  // ------------------------------------------------------------------
  assign lowvolt_detect_enable_out = lowvolt_detect_enable_r;
  assign lowvolt_level_out = {lowvolt_level_hi_r, lowvolt_level_lo_r};
  assign ext_pin_wake_enable_out = ext_pin_wake_enable_r;
  assign timer_clock_select_out = timer_clock_select_r;
  assign cpu_clock_select_out = cpu_clock_select_r;
  assign rc_freq_sel_out = {rc_freq_sel_hi_r, rc_freq_sel_lo_r};

  // Sleep also stops the main oscillator; idle keeps it so wake-up is quick.
  // sub clock stops main
  assign main_osc_enable_out = cpu_clock_select_r && (state_r != SLWC_SLEEP);
  assign sleep_mode_out = (state_r == SLWC_SLEEP);
  assign idle_mode_out = (state_r == SLWC_IDLE);

  assign cpu_hold_out = (state_r != SLWC_RUN);

endmodule : slwc_ctrl

// ---- hw/slwc_hold_timer.sv ----
// Down counter that holds execution for a loaded number of ticks.
`timescale 1ns/1ps
module slwc_hold_timer #(
  parameter int WIDTH = 10
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic load_in,
  input wire logic [WIDTH-1:0] load_val_in,
  input wire logic tick_in,
  output logic busy_out,
  output logic done_out
);
  logic [WIDTH-1:0] count_r;

  // A load always restarts the count, so a newer request overrides an older one.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      count_r <= '0;
    end else if (clk_en_in) begin
      if (load_in) begin
        count_r <= load_val_in;
      end else if (tick_in && count_r != '0) begin
        count_r <= count_r - WIDTH'(1);
      end
    end
  end

  assign busy_out = (count_r != '0);
  assign done_out = clk_en_in && !load_in && tick_in && (count_r == WIDTH'(1));
endmodule : slwc_hold_timer

// ---- hw/slwc_pkg.sv ----
// Constants shared by the clock, power-mode and low-voltage control block.
package slwc_pkg;

  // ------------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] OFF_LOWVOLT_WAKE = 3'h0;
  localparam logic [2:0] OFF_SYS_CLOCK = 3'h1;
  localparam logic [2:0] OFF_IRQ_STATUS = 3'h2;
  localparam logic [2:0] OFF_IRQ_MASK = 3'h3;
  localparam logic [2:0] OFF_BLOCK_STATE = 3'h4;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int LW_IRQ_EN_BIT = 7;
  localparam int LW_DET_EN_BIT = 6;
  localparam int LW_LEVEL_HI_BIT = 5;
  localparam int LW_LEVEL_LO_BIT = 4;
  localparam int LW_EXT_WAKE_BIT = 0;
  localparam int SC_TIMER_SEL_BIT = 6;
  localparam int SC_CPU_SEL_BIT = 5;
  localparam int SC_IDLE_BIT = 4;
  localparam int SC_RC_HI_BIT = 1;
  localparam int SC_RC_LO_BIT = 0;
  localparam int IRQ_LOWVOLT_BIT = 0;
  localparam int IRQ_WAKE_BIT = 1;
  localparam int IRQ_HOLD_DONE_BIT = 2;
  localparam int IRQ_W = 3;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic RST_TIMER_SEL = 1'b1;
  localparam logic RST_CPU_SEL = 1'b1;
  localparam logic RST_IDLE = 1'b0;
  localparam logic [7:0] RST_LOWVOLT_WAKE = 8'h00;
  localparam logic [2:0] RST_IRQ_MASK = 3'h0;

  // ------------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------------
  localparam logic [1:0] RC_4MHZ = 2'h3;
  localparam logic [1:0] RC_16MHZ = 2'h2;
  localparam logic [1:0] RC_8MHZ = 2'h1;
  localparam logic [1:0] RC_1MHZ = 2'h0;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int HOLD_W = 10;
  localparam int CLK_PERIOD_PS = 25000;
  localparam logic [9:0] SETTLE_LONG_CLK = 10'd510;
  localparam logic [9:0] SETTLE_SHORT_CLK = 10'd8;
  localparam int RC_HOLD_16M_PS = 1500000;
  localparam int RC_HOLD_8M_PS = 3000000;
  localparam int RC_HOLD_4M_PS = 5000000;
  localparam int RC_HOLD_1M_PS = 24000000;
  localparam logic [9:0] RC_HOLD_16M_CYC = 10'((RC_HOLD_16M_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [9:0] RC_HOLD_8M_CYC = 10'((RC_HOLD_8M_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [9:0] RC_HOLD_4M_CYC = 10'((RC_HOLD_4M_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [9:0] RC_HOLD_1M_CYC = 10'((RC_HOLD_1M_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  typedef enum logic [5:0] {
    SLWC_RUN      = 6'b00_0001,
    SLWC_SLEEP    = 6'b00_0010,
    SLWC_IDLE     = 6'b00_0100,
    SLWC_WAIT_OSC = 6'b00_1000,
    SLWC_SETTLE   = 6'b01_0000,
    SLWC_RC_HOLD  = 6'b10_0000
  } slwc_state_e;

endpackage : slwc_pkg

// ---- hw/slwc_sync2.sv ----
// Two-flop synchroniser for a single level.
`timescale 1ns/1ps
module slwc_sync2 (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_r;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      meta_r <= 1'b1;
      sync_out <= 1'b1;
    end else if (clk_en_in) begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : slwc_sync2

// ---- testbench/slwc_ctrl_checker.sv ----
// Port-level assertions for the clock, power-mode and low-voltage control block.
`timescale 1ns/1ps
module slwc_ctrl_checker
  import slwc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic [slwc_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [slwc_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [slwc_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic lowvolt_cmp_above_in,
  input wire logic sleep_instruction_in,
  input wire logic lowvolt_status_n_out,
  input wire logic lowvolt_detect_enable_out,
  input wire logic [1:0] lowvolt_level_out,
  input wire logic cpu_clock_select_out,
  input wire logic main_osc_enable_out,
  input wire logic [1:0] rc_freq_sel_out,
  input wire logic sleep_mode_out,
  input wire logic idle_mode_out,
  input wire logic cpu_hold_out
);
  import slwc_pkg::*;
  logic [7:0] wdata_q;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // Write data is kept one cycle so a field can be compared after the write lands.
  always_ff @(posedge clk_sys_in) begin
    wdata_q <= reg_wdata_in;
  end
  a_hold_in_lowpower: assert property ((sleep_mode_out || idle_mode_out) |-> cpu_hold_out)
    else $error("fetch not held in low-power mode");
  a_sub_stops_main: assert property (!cpu_clock_select_out |-> !main_osc_enable_out)
    else $error("main oscillator runs while sub clock drives cpu");
  a_sleep_osc_off: assert property (sleep_mode_out |-> !main_osc_enable_out)
    else $error("main oscillator runs in sleep");
  a_sleep_entry: assert property ((sleep_instruction_in && clk_en_in && !cpu_hold_out)
    |=> (sleep_mode_out != idle_mode_out)) else $error("sleep instruction not obeyed");
  a_wake_rsvd_zero: assert property ((reg_rd_in && clk_en_in && reg_addr_in == OFF_LOWVOLT_WAKE)
    |=> reg_rdata_out[3:1] == 3'h0) else $error("unused wake bits not zero");
  a_sys_rsvd_zero: assert property ((reg_rd_in && clk_en_in && reg_addr_in == OFF_SYS_CLOCK)
    |=> {reg_rdata_out[7], reg_rdata_out[3:2]} == 3'h0) else $error("unused sys bits not zero");
  a_sys_fields_load: assert property ((reg_wr_in && clk_en_in && reg_addr_in == OFF_SYS_CLOCK
    && !sleep_instruction_in) |=> rc_freq_sel_out == wdata_q[1:0]
    && cpu_clock_select_out == wdata_q[5]) else $error("clock fields not loaded");
  a_lv_fields_load: assert property ((reg_wr_in && clk_en_in && reg_addr_in == OFF_LOWVOLT_WAKE)
    |=> lowvolt_level_out == wdata_q[5:4] && lowvolt_detect_enable_out == wdata_q[6])
    else $error("detector fields not loaded");
  a_rc_change_holds: assert property ((reg_wr_in && clk_en_in && reg_addr_in == OFF_SYS_CLOCK
    && !cpu_hold_out && !sleep_instruction_in && reg_wdata_in[1:0] != rc_freq_sel_out)
    |=> cpu_hold_out [*8]) else $error("rc change did not hold fetch");
  a_status_above: assert property ((lowvolt_detect_enable_out && lowvolt_cmp_above_in
    && clk_en_in) [*4] |-> lowvolt_status_n_out) else $error("status low above threshold");
  a_status_below: assert property ((lowvolt_detect_enable_out && !lowvolt_cmp_above_in
    && clk_en_in) [*4] |-> !lowvolt_status_n_out) else $error("status high below threshold");
  a_status_off_one: assert property ((!lowvolt_detect_enable_out) [*3] |-> lowvolt_status_n_out)
    else $error("status low with detector off");
endmodule : slwc_ctrl_checker

bind slwc_ctrl slwc_ctrl_checker u_chk (
  .clk_sys_in(clk_sys_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .lowvolt_cmp_above_in(lowvolt_cmp_above_in), .sleep_instruction_in(sleep_instruction_in),
  .lowvolt_status_n_out(lowvolt_status_n_out),
  .lowvolt_detect_enable_out(lowvolt_detect_enable_out), .lowvolt_level_out(lowvolt_level_out),
  .cpu_clock_select_out(cpu_clock_select_out), .main_osc_enable_out(main_osc_enable_out),
  .rc_freq_sel_out(rc_freq_sel_out), .sleep_mode_out(sleep_mode_out),
  .idle_mode_out(idle_mode_out), .cpu_hold_out(cpu_hold_out)
);

// ---- testbench/slwc_ctrl_tb.sv ----
// Self-checking bench for the clock, power-mode and low-voltage control block.
`timescale 1ns/1ps
module slwc_ctrl_tb;
  import slwc_pkg::*;
  logic clk_sys_in, reset_in, clk_en_in, reg_wr_in, reg_rd_in;
  logic [ADDR_W-1:0] reg_addr_in;
  logic [DATA_W-1:0] reg_wdata_in, reg_rdata_out;
  logic [1:0] code_option_rc_in, lowvolt_level_out, rc_freq_sel_out;
  logic lowvolt_cmp_above_in, sleep_instruction_in, ext_int_n_in, wake_event_in;
  logic osc_stable_in, crystal_osc_in, cpu_clk_tick_in, irq_out, lowvolt_irq_req_out;
  logic lowvolt_status_n_out, lowvolt_detect_enable_out, ext_pin_wake_enable_out;
  logic timer_clock_select_out, cpu_clock_select_out, main_osc_enable_out;
  logic sleep_mode_out, idle_mode_out, cpu_hold_out;
  int n_fail, checks_done, n, t;
  // Settling time in ns per select code: 1, 8, 16 and 4 MHz.
  int rc_ns [4] = '{24000, 3000, 1500, 5000};
  int seq [4] = '{3, 0, 1, 2};

  slwc_ctrl DUT (.clk_sys_in, .reset_in, .clk_en_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .code_option_rc_in, .lowvolt_cmp_above_in,
    .sleep_instruction_in, .ext_int_n_in, .wake_event_in, .osc_stable_in, .crystal_osc_in,
    .cpu_clk_tick_in, .irq_out, .lowvolt_irq_req_out, .lowvolt_status_n_out,
    .lowvolt_detect_enable_out, .lowvolt_level_out, .ext_pin_wake_enable_out,
    .timer_clock_select_out, .cpu_clock_select_out, .main_osc_enable_out, .rc_freq_sel_out,
    .sleep_mode_out, .idle_mode_out, .cpu_hold_out);

  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  // A cpu clock tick every second cycle keeps settle counts distinct from cycle counts.
  initial begin
    cpu_clk_tick_in = 1'b0;
    forever @(posedge clk_sys_in) cpu_clk_tick_in <= ~cpu_clk_tick_in;
  end

  // ----------------------------------------------------------------
  // Access and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(16'(reg_rdata_out), 16'(e));
  endtask : rd
  // Counts held cycles, and the ticks seen once the block has left sleep or idle.
  task automatic hold_len(output int cyc, output int ticks);
    cyc = 0;
    ticks = 0;
    #1;
    while (cpu_hold_out === 1'b1 && cyc < 3000) begin
      cyc++;
      if (cpu_clk_tick_in === 1'b1 && sleep_mode_out === 1'b0 && idle_mode_out === 1'b0) ticks++;
      @(posedge clk_sys_in);
      #1;
    end
  endtask : hold_len
  task automatic pulse_sleep();
    @(posedge clk_sys_in);
    sleep_instruction_in <= 1'b1;
    @(posedge clk_sys_in);
    sleep_instruction_in <= 1'b0;
    #1;
  endtask : pulse_sleep
  task automatic set_lv(input logic v);
    @(posedge clk_sys_in);
    lowvolt_cmp_above_in <= v;
    repeat (4) @(posedge clk_sys_in);
    #1;
  endtask : set_lv
  task automatic summarize();
    $display("checks=%0d failures=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    n_fail = 0;
    checks_done = 0;
    {reset_in, clk_en_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = 15'h6000;
    {code_option_rc_in, lowvolt_cmp_above_in, sleep_instruction_in} = 4'b1010;
    {ext_int_n_in, wake_event_in, osc_stable_in, crystal_osc_in} = 4'b1010;
    repeat (12) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    rd(OFF_SYS_CLOCK, 8'h62);
    rd(OFF_LOWVOLT_WAKE, 8'h00);
    rd(3'h5, 8'h00);
    chk(16'(main_osc_enable_out), 16'h0001);
    foreach (seq[i]) begin
      wr(OFF_SYS_CLOCK, 8'hEC | 8'(seq[i]));
      hold_len(n, t);
      chk(16'(n), 16'(rc_ns[seq[i]] / 25));
      rd(OFF_SYS_CLOCK, 8'h60 | 8'(seq[i]));
    end
    rd(OFF_IRQ_STATUS, 8'h04);
    wr(OFF_IRQ_MASK, 8'h04);
    chk(16'(irq_out), 16'h0001);
    wr(OFF_IRQ_MASK, 8'h00);
    chk(16'(irq_out), 16'h0000);
    wr(OFF_IRQ_MASK, 8'h07);
    wr(OFF_IRQ_STATUS, 8'h04);
    chk(16'(irq_out), 16'h0000);
    for (int lv = 0; lv < 4; lv++) begin
      wr(OFF_LOWVOLT_WAKE, 8'h4E | 8'(lv << 4));
      chk(16'(lowvolt_level_out), 16'(lv));
      rd(OFF_LOWVOLT_WAKE, 8'h40 | 8'(lv << 4));
    end
    wr(OFF_LOWVOLT_WAKE, 8'hC1);
    chk(16'(ext_pin_wake_enable_out), 16'h0001);
    set_lv(1'b0);
    chk(16'(lowvolt_status_n_out), 16'h0000);
    chk(16'(lowvolt_irq_req_out), 16'h0001);
    rd(OFF_IRQ_STATUS, 8'h01);
    wr(OFF_IRQ_STATUS, 8'h01);
    set_lv(1'b1);
    rd(OFF_IRQ_STATUS, 8'h01);
    wr(OFF_LOWVOLT_WAKE, 8'h41);
    chk(16'(lowvolt_irq_req_out), 16'h0000);
    set_lv(1'b0);
    wr(OFF_LOWVOLT_WAKE, 8'h01);
    repeat (3) @(posedge clk_sys_in);
    rd(OFF_BLOCK_STATE, 8'h81);
    @(posedge clk_sys_in);
    clk_en_in <= 1'b0;
    pulse_sleep();
    chk(16'({sleep_mode_out, cpu_hold_out}), 16'h0000);
    @(posedge clk_sys_in);
    clk_en_in <= 1'b1;
    wr(OFF_IRQ_STATUS, 8'h07);
    @(posedge clk_sys_in);
    crystal_osc_in <= 1'b1;
    pulse_sleep();
    chk(16'({sleep_mode_out, main_osc_enable_out, cpu_hold_out}), 16'h0005);
    @(posedge clk_sys_in);
    ext_int_n_in <= 1'b0;
    @(posedge clk_sys_in);
    ext_int_n_in <= 1'b1;
    hold_len(n, t);
    chk(16'(t >= 510 && t <= 512), 16'h0001);
    rd(OFF_IRQ_STATUS, 8'h06);
    wr(OFF_LOWVOLT_WAKE, 8'h00);
    chk(16'(ext_pin_wake_enable_out), 16'h0000);
    wr(OFF_SYS_CLOCK, 8'h72);
    @(posedge clk_sys_in);
    crystal_osc_in <= 1'b0;
    pulse_sleep();
    chk(16'({idle_mode_out, main_osc_enable_out}), 16'h0003);
    @(posedge clk_sys_in);
    ext_int_n_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    ext_int_n_in <= 1'b1;
    #1;
    chk(16'(idle_mode_out), 16'h0001);
    @(posedge clk_sys_in);
    wake_event_in <= 1'b1;
    @(posedge clk_sys_in);
    wake_event_in <= 1'b0;
    hold_len(n, t);
    chk(16'(t >= 8 && t <= 10), 16'h0001);
    wr(OFF_SYS_CLOCK, 8'h02);
    chk(16'({main_osc_enable_out, timer_clock_select_out}), 16'h0000);
    hold_len(n, t);
    chk(16'(cpu_clock_select_out), 16'h0000);
    @(posedge clk_sys_in);
    crystal_osc_in <= 1'b1;
    wr(OFF_SYS_CLOCK, 8'h62);
    hold_len(n, t);
    chk(16'(t >= 510 && t <= 512), 16'h0001);
    @(posedge clk_sys_in);
    code_option_rc_in <= 2'h0;
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    rd(OFF_SYS_CLOCK, 8'h60);
    summarize();
  end

  // The whole sequence needs under 6000 cycles; this limit leaves wide margin.
  initial begin
    #500000;
    n_fail++;
    summarize();
  end
endmodule : slwc_ctrl_tb
